/* core/modsr_fabric.sv */
// fabric end: feeds products into one block, rounds, trims, saturates, groups
// assumes round_mode stable during a group; block inputs registered there
`timescale 1ns/1ns
module modsr_fabric
    import modsr_pkg::*;
#(
    parameter int FRAC      = 3,
    parameter int GROUP_LEN = 4,
    parameter int ROW_PIPE  = 2,
    parameter int SUM_W     = 48
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    // link
    modsr_if.fab                       lnk,
    // sample stream
    input  wire logic                  in_valid,
    output logic                       in_ready,
    input  wire logic [OP_W-1:0]       in_x,
    input  wire logic [OP_W-1:0]       in_y,
    input  wire logic                  in_last,
    // controls
    input  wire modsr_round_e          round_mode,
    input  wire logic                  use_chain,
    input  wire logic                  subtract_req,
    input  wire logic                  narrow_req,
    input  wire logic                  shift_req,
    // result
    output logic                       out_valid,
    output logic signed [SUM_W-1:0]    out_sum,
    output logic                       out_sat,
    // cross-row chain
    output logic [ACC_W-1:0]           row_chain_out
);

    localparam int               TRIM_W  = ACC_W - FRAC;
    localparam int               CNT_W   = $clog2(GROUP_LEN + 1);
    localparam logic [ACC_W-1:0] FIXED   = modsr_fixed_term(FRAC);
    localparam logic [TRIM_W-1:0] T_MAX  = {1'b0, {(TRIM_W-1){1'b1}}};
    localparam logic [TRIM_W-1:0] T_MIN  = {1'b1, {(TRIM_W-1){1'b0}}};
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(GROUP_LEN - 1);
    localparam logic [SUM_W-1:0] SUM_ZERO = '0;
    localparam int               ROW_LATENCY = ROW_PIPE;

    typedef enum logic [2:0] {
        FS_ACC,
        FS_SETTLE,
        FS_RND,
        FS_WAIT,
        FS_TRIM
    } modsr_fab_st_e;

    // ****************************************************************
    // state
    // ****************************************************************
    modsr_fab_st_e                st, next_st;
    logic [CNT_W-1:0]             cnt, next_cnt;
    logic                         ovf_seen, next_ovf_seen;
    logic                         last_seen, next_last_seen;
    logic signed [SUM_W-1:0]      gsum, next_gsum;
    logic [OP_W-1:0]              next_a, next_b;
    logic [ACC_W-1:0]             next_c;
    logic                         next_cin, next_loop, next_chain;
    logic                         next_ready, next_out_valid, next_out_sat;
    logic signed [SUM_W-1:0]      next_out_sum;
    logic                         var_bit;
    logic                         any_ovf;
    logic signed [TRIM_W-1:0]     trimmed;
    logic [ACC_W-1:0]             row_pipe      [ROW_PIPE];
    logic [ACC_W-1:0]             next_row_pipe [ROW_PIPE];

    // ****************************************************************
    // trimming and saturation
    // ****************************************************************
    always_comb begin
        any_ovf = ovf_seen | lnk.overflow_carry_flag;
        if (any_ovf) begin
            // wrapped sign is the opposite of the true sign
            trimmed = lnk.result_p[ACC_W-1] ? T_MAX : T_MIN;
        end else begin
            trimmed = lnk.result_p[ACC_W-1:FRAC];
        end
        if (round_mode == RND_EVEN) begin
            var_bit = lnk.result_p[FRAC];
        end else begin
            var_bit = lnk.result_p[ACC_W-1];
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        next_st        = st;
        next_cnt       = cnt;
        next_ovf_seen  = any_ovf;
        next_last_seen = last_seen;
        next_gsum      = gsum;
        next_a         = OP_ZERO;
        next_b         = OP_ZERO;
        next_c         = ACC_ZERO;
        next_cin       = 1'b0;
        next_loop      = 1'b1;
        next_chain     = use_chain;
        next_out_valid = 1'b0;
        next_out_sum   = out_sum;
        next_out_sat   = out_sat;
        unique case (st)
            FS_ACC: begin
                if (cnt == CNT_ZERO) begin
                    next_ovf_seen = 1'b0;
                end
                if (in_valid && in_ready) begin
                    next_a    = in_x;
                    next_b    = in_y;
                    next_loop = (cnt != CNT_ZERO);
                    if (round_mode == RND_PROD_ZERO) begin
                        next_c   = FIXED;
                        next_cin = in_x[OP_W-1] ^ in_y[OP_W-1];
                    end
                    next_cnt       = cnt + CNT_ONE;
                    next_last_seen = in_last;
                    if (in_last || cnt == CNT_LAST) begin
                        next_st = FS_SETTLE;
                    end
                end
            end
            FS_SETTLE: begin
                if (round_mode == RND_EVEN || round_mode == RND_ZERO) begin
                    next_st = FS_RND;
                end else begin
                    next_st = FS_TRIM;
                end
            end
            FS_RND: begin
                // variable bit rides the multiplier, fixed term rides C
                next_a  = {{(OP_W-1){1'b0}}, var_bit};
                next_b  = OP_ONE;
                next_c  = FIXED;
                next_st = FS_WAIT;
            end
            FS_WAIT: begin
                next_st = FS_TRIM;
            end
            FS_TRIM: begin
                next_cnt       = CNT_ZERO;
                next_ovf_seen  = 1'b0;
                next_last_seen = 1'b0;
                next_loop      = 1'b0;
                if (last_seen) begin
                    next_gsum      = SUM_ZERO;
                    next_out_valid = 1'b1;
                    next_out_sum   = gsum + SUM_W'(trimmed);
                    next_out_sat   = any_ovf;
                end else begin
                    next_gsum      = gsum + SUM_W'(trimmed);
                end
                next_st = FS_ACC;
            end
        endcase
        next_ready = (next_st == FS_ACC);
    end

    // ****************************************************************
    // cross-row chain pipeline, latency ROW_LATENCY cycles
    // ****************************************************************
    always_comb begin
        next_row_pipe[0] = lnk.chain_out;
        for (int i = 1; i < ROW_PIPE; i++) begin
            next_row_pipe[i] = row_pipe[i-1];
        end
    end

    assign row_chain_out = row_pipe[ROW_LATENCY-1];

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st                           <= FS_ACC;
            cnt                          <= CNT_ZERO;
            ovf_seen                     <= 1'b0;
            last_seen                    <= 1'b0;
            gsum                         <= SUM_ZERO;
            in_ready                     <= 1'b0;
            out_valid                    <= 1'b0;
            out_sum                      <= SUM_ZERO;
            out_sat                      <= 1'b0;
            lnk.mul_a                    <= OP_ZERO;
            lnk.mul_b                    <= OP_ZERO;
            lnk.addend_c                 <= ACC_ZERO;
            lnk.adder_carry_input        <= 1'b0;
            lnk.loopback_select          <= 1'b0;
            lnk.chain_select             <= 1'b0;
            lnk.subtract                 <= 1'b0;
            lnk.dual_narrow_product_mode <= 1'b0;
            lnk.shift_right_seventeen    <= 1'b0;
            for (int i = 0; i < ROW_PIPE; i++) begin
                row_pipe[i] <= ACC_ZERO;
            end
        end else begin
            st                           <= next_st;
            cnt                          <= next_cnt;
            ovf_seen                     <= next_ovf_seen;
            last_seen                    <= next_last_seen;
            gsum                         <= next_gsum;
            in_ready                     <= next_ready;
            out_valid                    <= next_out_valid;
            out_sum                      <= next_out_sum;
            out_sat                      <= next_out_sat;
            lnk.mul_a                    <= next_a;
            lnk.mul_b                    <= next_b;
            lnk.addend_c                 <= next_c;
            lnk.adder_carry_input        <= next_cin;
            lnk.loopback_select          <= next_loop;
            lnk.chain_select             <= next_chain;
            // keep the rounding bit at the lsb
            lnk.subtract                 <= subtract_req && st != FS_RND;
            lnk.dual_narrow_product_mode <= narrow_req && st != FS_RND;
            lnk.shift_right_seventeen    <= shift_req;
            for (int i = 0; i < ROW_PIPE; i++) begin
                row_pipe[i] <= next_row_pipe[i];
            end
        end
    end

endmodule : modsr_fabric

/* core/modsr_mac.sv */
// multiply-accumulate block: multiplier, operand-d select, 44-bit adder
// assumes inputs arrive registered from fabric; chain_in from left neighbour
`timescale 1ns/1ns
module modsr_mac
    import modsr_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic arst_n,
    // link
    modsr_if.mac      lnk,
    // user side
    input  wire logic hold
);

    // ****************************************************************
    // multiplier
    // ****************************************************************
    logic signed [2*OP_W-1:0]   prod_n;
    logic signed [2*HALF_W:0]   prod_d;
    logic signed [EXT_W-1:0]    prod_x;
    logic        [ACC_W-1:0]    opd;
    logic signed [EXT_W-1:0]    c_x;
    logic signed [EXT_W-1:0]    d_x;
    logic        [EXT_W-1:0]    cin_x;
    logic        [EXT_W-1:0]    sum_x;
    logic        [ACC_W-1:0]    next_p;
    logic                       next_ovf;

    assign prod_n = $signed(lnk.mul_a) * $signed(lnk.mul_b);
    assign prod_d = $signed(lnk.mul_a[HALF_W-1:0]) * $signed(lnk.mul_b[OP_W-1:HALF_W])
                  + $signed(lnk.mul_a[OP_W-1:HALF_W]) * $signed(lnk.mul_b[HALF_W-1:0]);

    // ****************************************************************
    // operand d
    // ****************************************************************
    modsr_opd_sel #(
        .W  (ACC_W),
        .SH (SHIFT_N)
    ) u_opd (
        .chain_in              (lnk.chain_in),
        .own_p                 (lnk.result_p),
        .chain_select          (lnk.chain_select),
        .loopback_select       (lnk.loopback_select),
        .shift_right_seventeen (lnk.shift_right_seventeen),
        .opd                   (opd)
    );

    // ****************************************************************
    // adder
    // ****************************************************************
    always_comb begin
        if (lnk.dual_narrow_product_mode) begin
            prod_x = EXT_W'(prod_d) <<< DOT_SCALE;
        end else begin
            prod_x = EXT_W'(prod_n);
        end
        c_x   = EXT_W'($signed(lnk.addend_c));
        d_x   = EXT_W'($signed(opd));
        cin_x = {{(EXT_W-1){1'b0}}, lnk.adder_carry_input};
        if (lnk.subtract) begin
            sum_x = c_x + d_x + cin_x - prod_x;
        end else begin
            sum_x = prod_x + c_x + d_x + cin_x;
        end
        // result does not fit 44 signed bits when top three differ
        next_ovf = (sum_x[EXT_W-1:ACC_W-1] != '0)
                && (sum_x[EXT_W-1:ACC_W-1] != '1);
        next_p   = sum_x[ACC_W-1:0];
    end

    // ****************************************************************
    // output register
    // ****************************************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lnk.result_p            <= ACC_ZERO;
            lnk.chain_out           <= ACC_ZERO;
            lnk.overflow_carry_flag <= 1'b0;
        end else if (!hold) begin
            lnk.result_p            <= next_p;
            lnk.chain_out           <= next_p;
            lnk.overflow_carry_flag <= next_ovf;
        end
    end

endmodule : modsr_mac

/* core/modsr_opd_sel.sv */
// operand-d selector and arithmetic right shifter in front of the adder
// assumes purely combinational use; sources come straight from ports or p
`timescale 1ns/1ns
module modsr_opd_sel
    import modsr_pkg::*;
#(
    parameter int W  = ACC_W,
    parameter int SH = SHIFT_N
) (
    // sources
    input  wire logic [W-1:0] chain_in,
    input  wire logic [W-1:0] own_p,
    // controls
    input  wire logic         chain_select,
    input  wire logic         loopback_select,
    input  wire logic         shift_right_seventeen,
    // operand d
    output logic      [W-1:0] opd
);

    logic [W-1:0] src;

    always_comb begin
        if (chain_select) begin
            src = chain_in;
        end else if (loopback_select) begin
            src = own_p;
        end else begin
            src = '0;
        end
        if (shift_right_seventeen) begin
            opd = {{SH{src[W-1]}}, src[W-1:SH]};
        end else begin
            opd = src;
        end
    end

endmodule : modsr_opd_sel

/* pkg/modsr_if.sv */
// link between one multiply-accumulate block and the fabric that drives it
// assumes the bench drives chain_in; chain_out returns to the fabric row-chain pipe
`timescale 1ns/1ns
interface modsr_if;
    import modsr_pkg::*;

    logic [OP_W-1:0]  mul_a;
    logic [OP_W-1:0]  mul_b;
    logic [ACC_W-1:0] addend_c;
    logic             adder_carry_input;
    logic             subtract;
    logic             dual_narrow_product_mode;
    logic             chain_select;
    logic             loopback_select;
    logic             shift_right_seventeen;
    logic [ACC_W-1:0] result_p;
    logic             overflow_carry_flag;
    logic [ACC_W-1:0] chain_in;
    logic [ACC_W-1:0] chain_out;

    modport mac (
        input  mul_a, mul_b, addend_c, adder_carry_input, subtract,
        input  dual_narrow_product_mode, chain_select, loopback_select,
        input  shift_right_seventeen, chain_in,
        output result_p, overflow_carry_flag, chain_out
    );

    modport fab (
        output mul_a, mul_b, addend_c, adder_carry_input, subtract,
        output dual_narrow_product_mode, chain_select, loopback_select,
        output shift_right_seventeen,
        input  result_p, overflow_carry_flag, chain_out
    );

endinterface : modsr_if

/* pkg/modsr_pkg.sv */
// constants and types shared by the operand-d block, its interface and both ends
// assumes one fabric clock; no file here holds logic
//
// Function
// - round: add fixed and variable terms, truncate
// - variable term is one bit at LSB
// - fixed term on C, 0.011 for three fractions
// - round-to-even takes variable bit from units bit
// - round-toward-zero takes variable bit from sign
// - chain: fixed on C and variable bit on multiplier, in one added last step
// - trimming of final result done in fabric
// - large sums split into trimmed groups
// - product sign is XOR of operand signs
// - trim partial sums when only products add
// - 44-bit chain in/out, chain select picks input
// - chain out wired straight to next chain in
// - cross-row chain pipeline latency is accounted
// - adder drives overflow/carry flag
// - saturate from overflow flag and output bit 43
// - shift control right-shifts operand D by 17
// - both selects low gives zero operand D
// - chain select high gives chain input
// - loopback select with chain select low gives own output
// - sum is product plus C, D, carry; subtract
// - chain input passes unregistered into adder
package modsr_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int ACC_W     = 44;
    localparam int EXT_W     = ACC_W + 2;
    localparam int OP_W      = 18;
    localparam int HALF_W    = 9;
    localparam int DOT_SCALE = 9;
    localparam int SHIFT_N   = 17;

    // ****************************************************************
    // reset and fixed values
    // ****************************************************************
    localparam logic [ACC_W-1:0] ACC_ZERO = 44'h0;
    localparam logic [OP_W-1:0]  OP_ZERO  = 18'h0;
    localparam logic [OP_W-1:0]  OP_ONE   = 18'h1;

    // ****************************************************************
    // rounding
    // ****************************************************************
    typedef enum logic [1:0] {
        RND_NONE,
        RND_EVEN,
        RND_ZERO,
        RND_PROD_ZERO
    } modsr_round_e;

    // fixed term: just under one half in the lowest integer position
    function automatic logic [ACC_W-1:0] modsr_fixed_term(input int frac);
        modsr_fixed_term = (ACC_W'(1) << (frac - 1)) - ACC_W'(1);
    endfunction : modsr_fixed_term

endpackage : modsr_pkg

/* verif/modsr_link_properties.sv */
// concurrent checks on the link between the fabric end and one block
// assumes the bench instantiates it beside the link and hooks each signal by name
`timescale 1ns/1ns
module modsr_link_properties
    import modsr_pkg::*;
(
    // clock and reset
    input wire logic             clock,
    input wire logic             arst_n,
    // fabric to block
    input wire logic [OP_W-1:0]  mul_a,
    input wire logic [OP_W-1:0]  mul_b,
    input wire logic [ACC_W-1:0] addend_c,
    input wire logic             adder_carry_input,
    input wire logic             subtract,
    input wire logic             dual_narrow_product_mode,
    input wire logic             chain_select,
    input wire logic             loopback_select,
    input wire logic             shift_right_seventeen,
    input wire logic [ACC_W-1:0] chain_in,
    input wire logic             hold,
    // block to fabric
    input wire logic [ACC_W-1:0] result_p,
    input wire logic             overflow_carry_flag,
    input wire logic [ACC_W-1:0] chain_out
);
    // ****************************************************************
    // reference adder
    // ****************************************************************
    logic        [ACC_W-1:0] src;
    logic        [ACC_W-1:0] opd;
    logic signed [EXT_W-1:0] prod;
    logic signed [EXT_W-1:0] sum;
    logic                    ovf;

    always_comb begin
        src  = chain_select ? chain_in : (loopback_select ? result_p : ACC_ZERO);
        opd  = shift_right_seventeen ? {{SHIFT_N{src[ACC_W-1]}}, src[ACC_W-1:SHIFT_N]} : src;
        prod = $signed(mul_a) * $signed(mul_b);
        if (dual_narrow_product_mode) begin
            prod = ($signed(mul_a[8:0]) * $signed(mul_b[17:9])
                    + $signed(mul_a[17:9]) * $signed(mul_b[8:0])) <<< DOT_SCALE;
        end
        sum  = $signed(addend_c) + $signed(opd) + $signed({1'b0, adder_carry_input});
        sum  = subtract ? sum - prod : sum + prod;
        ovf  = sum[EXT_W-1:ACC_W-1] != 3'b000 && sum[EXT_W-1:ACC_W-1] != 3'b111;
    end

    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_zero_operand:
        assert property (!hold && !chain_select && !loopback_select
            |=> result_p == $past(sum[ACC_W-1:0])) else $error("sum wrong with no d source");
    a_chain_source:
        assert property (!hold && chain_select |=> result_p == $past(sum[ACC_W-1:0]))
            else $error("sum wrong with chain input as d");
    a_loop_source:
        assert property (!hold && !chain_select && loopback_select
            |=> result_p == $past(sum[ACC_W-1:0])) else $error("sum wrong with loopback as d");
    a_shift_sign:
        assert property (!hold && shift_right_seventeen && (chain_select || loopback_select)
            |=> result_p == $past(sum[ACC_W-1:0])) else $error("shifted d operand wrong");
    a_sub_sum:
        assert property (!hold && subtract |=> result_p == $past(sum[ACC_W-1:0]))
            else $error("subtract result wrong");
    a_flag_overflow:
        assert property (!hold |=> overflow_carry_flag == $past(ovf))
            else $error("overflow flag wrong");
    a_chain_copy:
        assert property (!hold |=> chain_out == $past(sum[ACC_W-1:0]))
            else $error("chain output differs from sum");
    a_accum_each:
        assert property ((!hold && loopback_select && !chain_select)[*2]
            |=> result_p == $past(sum[ACC_W-1:0])) else $error("back to back accumulate wrong");
endmodule : modsr_link_properties

/* verif/test_mac_operand_d_select_round.sv */
// self-checking bench: fabric end and one block joined by the link
// assumes both design ends and the link checker are compiled first
`timescale 1ns/1ns
module test_mac_operand_d_select_round;
    import modsr_pkg::*;
    // ****************************************************************
    // setup
    // ****************************************************************
    localparam int     FRAC = 3;
    localparam int     GL   = 4;
    localparam int     RP   = 2;
    localparam int     TMAX = 30000;
    localparam longint FIX  = (longint'(1) << (FRAC - 1)) - 1;
    logic                     clock, arst_n, hold, in_valid, in_ready, in_last, out_valid, out_sat;
    logic                     use_chain, subtract_req, narrow_req, shift_req;
    logic        [OP_W-1:0]   in_x, in_y;
    logic signed [47:0]       out_sum;
    logic        [ACC_W-1:0]  row_chain_out;
    logic        [ACC_W-1:0]  hist [RP];
    modsr_round_e             round_mode;
    int                       bad_count, cmp_count, cycles, seed, since;
    logic        [OP_W-1:0]   corner [4] = '{18'h00014, 18'h0000c, 18'h3fff4, 18'h3ffec};

    modsr_if u_modsr_if ();
    modsr_mac u_modsr_mac (.clock(clock), .arst_n(arst_n), .lnk(u_modsr_if.mac), .hold(hold));
    modsr_fabric #(.FRAC(FRAC), .GROUP_LEN(GL), .ROW_PIPE(RP), .SUM_W(48)) u_modsr_fabric (
        .clock(clock), .arst_n(arst_n), .lnk(u_modsr_if.fab), .in_valid(in_valid),
        .in_ready(in_ready), .in_x(in_x), .in_y(in_y), .in_last(in_last),
        .round_mode(round_mode), .use_chain(use_chain), .subtract_req(subtract_req),
        .narrow_req(narrow_req), .shift_req(shift_req), .out_valid(out_valid),
        .out_sum(out_sum), .out_sat(out_sat), .row_chain_out(row_chain_out));
    modsr_link_properties u_modsr_link_properties (
        .clock(clock), .arst_n(arst_n), .mul_a(u_modsr_if.mul_a), .mul_b(u_modsr_if.mul_b),
        .addend_c(u_modsr_if.addend_c), .adder_carry_input(u_modsr_if.adder_carry_input),
        .subtract(u_modsr_if.subtract),
        .dual_narrow_product_mode(u_modsr_if.dual_narrow_product_mode),
        .chain_select(u_modsr_if.chain_select), .loopback_select(u_modsr_if.loopback_select),
        .shift_right_seventeen(u_modsr_if.shift_right_seventeen),
        .chain_in(u_modsr_if.chain_in), .hold(hold), .result_p(u_modsr_if.result_p),
        .overflow_carry_flag(u_modsr_if.overflow_carry_flag), .chain_out(u_modsr_if.chain_out));

    always #4 clock = ~clock;

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic finish_test();
        if (bad_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test

    function automatic longint prod(logic [OP_W-1:0] a, logic [OP_W-1:0] b, logic nar);
        if (nar) return (longint'($signed(a[8:0])) * longint'($signed(b[17:9]))
                        + longint'($signed(a[17:9])) * longint'($signed(b[8:0]))) * 512;
        return longint'($signed(a)) * longint'($signed(b));
    endfunction : prod

    function automatic longint trim(longint a, modsr_round_e m);
        if (m == RND_EVEN) a += FIX + longint'(a[FRAC]);
        if (m == RND_ZERO) a += FIX + longint'(a < 0);
        return a >>> FRAC;
    endfunction : trim

    task automatic do_reset();
        arst_n = 1'b0;
        in_valid = 1'b0;
        repeat (10) @(negedge clock);
        arst_n = 1'b1;
    endtask : do_reset

    // request held from a falling edge until the rising edge that sees in_ready high
    task automatic send(input logic [OP_W-1:0] x, input logic [OP_W-1:0] y, input logic last);
        int n;
        in_valid = 1'b1;
        in_x = x;
        in_y = y;
        in_last = last;
        n = 0;
        while (in_ready !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
    endtask : send

    // fx of zero draws random factors, otherwise fx times one
    task automatic run_txn(input int n, input modsr_round_e m, input logic nar,
                           input logic [OP_W-1:0] fx);
        logic [OP_W-1:0] x, y;
        longint          acc, tot, p;
        int              k;
        round_mode = m;
        narrow_req = nar;
        acc = 0;
        tot = 0;
        for (int i = 0; i < n; i++) begin
            x = (fx != 0) ? fx : 18'($random(seed));
            y = (fx != 0) ? 18'h1 : 18'($random(seed));
            send(x, y, i == n - 1);
            p = prod(x, y, nar);
            if (m == RND_PROD_ZERO) p += FIX + longint'(x[17] ^ y[17]);
            acc += p;
            if (i % GL == GL - 1 || i == n - 1) begin
                tot += trim(acc, m);
                acc = 0;
            end
        end
        in_valid = 1'b0;
        in_last = 1'b0;
        k = 0;
        while (out_valid !== 1'b1 && k < 40) begin
            @(negedge clock);
            k++;
        end
        check({63'h0, out_valid}, 64'h1);
        check({16'h0, $unsigned(out_sum)}, {16'h0, tot[47:0]});
        check({63'h0, out_sat}, 64'h0);
    endtask : run_txn

    task automatic run_scored();
        modsr_round_e m;
        for (int r = 0; r < 4; r++) begin
            foreach (corner[c]) run_txn(1, modsr_round_e'(r), 1'b0, corner[c]);
        end
        run_txn(8, RND_EVEN, 1'b0, 18'h0);
        repeat (40) begin
            m = modsr_round_e'($random(seed) & 3);
            run_txn(1 + ($random(seed) & 7) + ($random(seed) & 1), m,
                    1'($random(seed)), 18'h0);
        end
    endtask : run_scored

    // ****************************************************************
    // free traffic on the link chain input
    // ****************************************************************
    always @(negedge clock) u_modsr_if.chain_in <= {12'($random(seed)), 32'($random(seed))};

    always @(negedge clock) begin
        since <= (arst_n !== 1'b1) ? 0 : since + 1;
        if (since > RP && arst_n === 1'b1) check({20'h0, row_chain_out}, {20'h0, hist[RP-1]});
        for (int i = RP - 1; i > 0; i--) hist[i] <= hist[i - 1];
        hist[0] <= u_modsr_if.chain_out;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == TMAX) begin
            bad_count++;
            finish_test();
        end
    end

    initial begin
        seed = 32'habc4e6fc;
        {clock, hold, in_valid, in_last, use_chain, subtract_req, narrow_req, shift_req} = '0;
        {in_x, in_y, bad_count, cmp_count, cycles, since} = '0;
        round_mode = RND_NONE;
        u_modsr_if.chain_in = '0;
        do_reset();
        run_scored();
        repeat (600) begin
            @(negedge clock);
            {use_chain, subtract_req, shift_req, narrow_req} = 4'($random(seed));
            hold = ($random(seed) & 7) == 0;
            {in_valid, in_last} = {1'($random(seed)), ($random(seed) & 3) == 0};
            {in_x, in_y} = {18'($random(seed)), 18'($random(seed))};
        end
        {use_chain, subtract_req, shift_req, narrow_req, hold} = '0;
        do_reset();
        run_scored();
        finish_test();
    end
endmodule : test_mac_operand_d_select_round
